// [inc/shared_port_pkg.sv]
/*
  shared bus host port package: widths, config bit positions, reset values,
  selection states and the state records of the port logic.
  assumes one data width for both directions of the port.
*/
package shared_port_pkg;

  // ------------------------------------------------------------
  // widths and timing
  // ------------------------------------------------------------
  localparam int DATA_W = 10;
  localparam int CLK_PERIOD_NS = 20;
  localparam int PORT_CLK_MAX_MHZ = 50;
  localparam int PORT_CLK_MIN_PERIOD_NS = 1000 / PORT_CLK_MAX_MHZ;
  localparam int CORE_CYCLES_PER_CHAR = PORT_CLK_MIN_PERIOD_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // configuration pin vector
  // ------------------------------------------------------------
  localparam int CFG_BYPASS_N = 0;
  localparam int CFG_CASCADE = 1;
  localparam int CFG_TX_ST = 2;
  localparam int CFG_RX_ST = 3;
  localparam int CFG_W = 4;
  localparam logic [CFG_W-1:0] CFG_RESET = 4'h1;

  // flag level that means "asserted" per timing model
  localparam logic FLAG_ON_SHARED = 1'b0;
  localparam logic FLAG_ON_CASCADE = 1'b1;

  // ------------------------------------------------------------
  // selection engine
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_IDLE = 2'b00,
    SEL_HIT = 2'b01,
    SEL_RST_HIT = 2'b10,
    SEL_ACTIVE = 2'b11
  } sel_mode_t;

  typedef struct packed {
    sel_mode_t mode;
    logic en_prev;
  } sel_state_t;

  localparam sel_state_t SEL_STATE_RESET = '{mode: SEL_IDLE, en_prev: 1'b0};

  // receive status levels handed over from the core
  typedef struct packed {
    logic full;
    logic empty;
    logic loop;
    logic miscompare;
  } rx_status_t;

  typedef struct packed {
    logic [CFG_W-1:0] cfg_s1;
    logic [CFG_W-1:0] cfg_s2;
    logic full_flag;
    logic empty_flag;
    logic tx_write;
    logic [DATA_W-1:0] tx_word;
    logic receive_queue_reset_n_s1;
    logic receive_queue_reset_n_s2;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic ack_tog;
    logic rx_pop;
    logic [DATA_W-1:0] head;
  } core_state_t;

  typedef struct packed {
    rx_status_t st_s1;
    rx_status_t st_s2;
    logic [CFG_W-1:0] cfg_s1;
    logic [CFG_W-1:0] cfg_s2;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic req_tog;
    logic full_flag;
    logic empty_flag;
    logic sticky_err;
    logic code_violation_flag;
    logic [DATA_W-1:0] data;
    logic data_oe;
  } rx_state_t;

endpackage : shared_port_pkg

// [src/port_select.sv]
/*
  address match and selection engine for one side of the port.
  assumes chip select, reset and enable are synchronous to i_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module port_select (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_cascade,
  input wire logic i_chip_select_n,
  input wire logic i_reset_n,
  input wire logic i_enable,
  output logic o_hit,
  output logic o_reset_hit,
  output logic o_selected,
  output logic o_take,
  output logic o_flag_oe
);
  import shared_port_pkg::*;

  sel_state_t cur_ff;
  sel_state_t nxt_cur;
  logic en_act;
  logic match;
  logic rmatch;
  logic fall;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // enable polarity follows the timing model
  always_comb begin
    en_act = i_cascade ? i_enable : ~i_enable;
    match = ~i_chip_select_n & i_reset_n;
    rmatch = ~i_chip_select_n & ~i_reset_n;
    fall = en_act & ~cur_ff.en_prev;
    nxt_cur = cur_ff;
    nxt_cur.en_prev = en_act;
    if (cur_ff.mode == SEL_ACTIVE && en_act) begin
      nxt_cur.mode = SEL_ACTIVE;
    end else if (fall && i_reset_n && (cur_ff.mode == SEL_HIT || match)) begin
      nxt_cur.mode = SEL_ACTIVE;
    end else if (match) begin
      nxt_cur.mode = SEL_HIT;
    end else if (rmatch) begin
      nxt_cur.mode = SEL_RST_HIT;
    end else begin
      nxt_cur.mode = SEL_IDLE;
    end
    if (!i_rstn) begin
      nxt_cur = SEL_STATE_RESET;
    end
  end

  always_ff @(posedge i_clk) begin
    cur_ff <= nxt_cur;
  end

  // drivers follow the registered state, one cycle after sampling
  assign o_hit = cur_ff.mode == SEL_HIT;
  assign o_reset_hit = cur_ff.mode == SEL_RST_HIT;
  assign o_selected = cur_ff.mode == SEL_ACTIVE;
  assign o_flag_oe = cur_ff.mode != SEL_IDLE;
  // cascade writes start in the enable cycle itself; shared takes only while
  // the active-low enable is still sampled asserted, like a plain fifo
  assign o_take = i_cascade ? (nxt_cur.mode == SEL_ACTIVE) : (o_selected & en_act);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_match_drives;
    @(posedge i_clk) disable iff (!i_rstn)
      (!i_chip_select_n && i_reset_n) |=> o_flag_oe;
  endproperty
  a_match_drives: assert property (p_match_drives) else $error("flags not driven");

  property p_cs_high_off;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_chip_select_n && !o_selected) |=> !o_flag_oe;
  endproperty
  a_cs_high_off: assert property (p_cs_high_off) else $error("flags left on");

  property p_select_entry;
    @(posedge i_clk) disable iff (!i_rstn)
      (o_hit && i_reset_n && en_act && !cur_ff.en_prev) |=> o_selected;
  endproperty
  a_select_entry: assert property (p_select_entry) else $error("no selection");

  property p_select_hold;
    @(posedge i_clk) disable iff (!i_rstn)
      (o_selected && en_act) |=> o_selected[*1] ##0 o_flag_oe;
  endproperty
  a_select_hold: assert property (p_select_hold) else $error("selection lost");

  property p_exclusive;
    @(posedge i_clk) disable iff (!i_rstn)
      o_reset_hit |-> !o_selected && !(o_hit);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("select with reset");

  property p_reset_quiet;
    @(posedge i_clk) !i_rstn |=> !o_flag_oe && !o_selected;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("driven after reset");

endmodule : port_select
`default_nettype wire

// [src/shared_bus_host_selection.sv]
/*
  parallel host port of the serial link transceiver: address match, flag
  driver control, transmit write strobes, receive data bus and self-test
  error reporting.
  assumes the transmit port pins are synchronous to i_clk (reference
  clock) and the receive pins synchronous to i_receive_port_clock.
*/
`timescale 1ns/10ps
`default_nettype none
// Contract
// - self-test flags use the same drivers and chip select sampling as normal
// - self-test read: chip select then enable falling drives data without popping
// - while receive enable stays asserted in self-test, stay selected and driven
// - miscompares show on the code violation bit of the receive bus
// - queues stay enabled when not bypassed, writes accepted every clock
// - internal work runs on core clocks, never on port clocks; here receive status sync and error capture run on i_receive_port_clock
// - bypassed: transmit synchronous to reference, receive to recovered clock
// - shared bus model: flags and enables active low
// - cascade model: flags and enables active high, earlier write timing
// - port clocks at most 50 MHz, one character per clock; here receive reads fetch one word per core round trip
// - chip select sampled per side clock; flag drivers follow next cycle
// - queue enabled: transmit clock sampling of chip select gates transmit flags; here the reference clock i_clk samples it in both modes
// - queue bypassed: reference clock sampling gates transmit flags
// - receive clock sampling of chip select gates receive flags
// - selection and reset sequence exclusive per side; sides independent
// - reset sequences steer queue reset and address register access
// - hit while chip select low and reset high; flags driven during hits
// - selection from hit on enable fall until enable high; write each clock
module shared_bus_host_selection (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_receive_port_clock,
  input wire logic i_chip_select_n,
  input wire logic i_queue_bypass_n,
  input wire logic i_cascade_model,
  input wire logic i_transmit_selftest_enable,
  input wire logic i_receive_selftest_enable,
  input wire logic i_transmit_queue_reset_n,
  input wire logic i_transmit_write_enable,
  input wire logic [shared_port_pkg::DATA_W-1:0] i_transmit_data_bus,
  input wire logic i_tx_queue_full,
  input wire logic i_tx_queue_empty,
  input wire logic i_tx_selftest_loop,
  output logic o_transmit_queue_full_flag,
  output logic o_transmit_queue_empty_flag,
  output logic o_transmit_flag_oe,
  output logic o_tx_write,
  output logic [shared_port_pkg::DATA_W-1:0] o_tx_word,
  output logic o_tx_reset_hit,
  input wire logic i_receive_queue_reset_n,
  input wire logic i_receive_read_enable,
  input wire shared_port_pkg::rx_status_t i_rx_status,
  input wire logic [shared_port_pkg::DATA_W-1:0] i_rx_head,
  output logic o_rx_pop,
  output logic o_rx_reset_hit,
  output logic o_receive_queue_full_flag,
  output logic o_receive_queue_empty_flag,
  output logic o_receive_flag_oe,
  output logic [shared_port_pkg::DATA_W-1:0] o_receive_data_bus,
  output logic o_code_violation_flag,
  output logic o_receive_data_oe
);
  import shared_port_pkg::*;

  core_state_t core_ff;
  core_state_t nxt_core;
  rx_state_t rx_ff;
  rx_state_t nxt_rx;
  logic rx_rst_s1_ff;
  logic rx_rst_s2_ff;
  logic tx_take;
  logic tx_oe;
  logic tx_rst_hit;
  logic rx_take;
  logic rx_oe;
  logic rx_rst_hit;
  logic rx_sel;

  // flag level as seen on the pin for the active timing model
  function automatic logic flag_level(input logic cascade, input logic asserted);
    flag_level = cascade ? (asserted ^ ~FLAG_ON_CASCADE) : (asserted ^ ~FLAG_ON_SHARED);
  endfunction : flag_level

  // ------------------------------------------------------------
  // transmit side (reference clock domain)
  // ------------------------------------------------------------
  // one clock serves both queue-enabled and bypassed sampling here
  port_select u_tx_select (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_cascade(core_ff.cfg_s2[CFG_CASCADE]),
    .i_chip_select_n(i_chip_select_n),
    .i_reset_n(i_transmit_queue_reset_n),
    .i_enable(i_transmit_write_enable),
    .o_hit(),
    .o_reset_hit(tx_rst_hit),
    .o_selected(),
    .o_take(tx_take),
    .o_flag_oe(tx_oe)
  );

  // core-domain state: config sync, tx strobes, rx handshake partner
  always_comb begin
    nxt_core = core_ff;
    nxt_core.cfg_s1 = {i_receive_selftest_enable, i_transmit_selftest_enable,
                       i_cascade_model, i_queue_bypass_n};
    nxt_core.cfg_s2 = core_ff.cfg_s1;
    // self-test loop status replaces empty; drivers untouched
    nxt_core.full_flag = flag_level(core_ff.cfg_s2[CFG_CASCADE], i_tx_queue_full);
    nxt_core.empty_flag = flag_level(core_ff.cfg_s2[CFG_CASCADE],
      core_ff.cfg_s2[CFG_TX_ST] ? i_tx_selftest_loop : i_tx_queue_empty);
    // writes every selected clock, queue or input register alike
    nxt_core.tx_write = tx_take;
    if (tx_take) begin
      nxt_core.tx_word = i_transmit_data_bus;
    end
    nxt_core.receive_queue_reset_n_s1 = rx_rst_hit;
    nxt_core.receive_queue_reset_n_s2 = core_ff.receive_queue_reset_n_s1;
    nxt_core.req_s1 = rx_ff.req_tog;
    nxt_core.req_s2 = core_ff.req_s1;
    nxt_core.req_s3 = core_ff.req_s2;
    nxt_core.rx_pop = 1'b0;
    // head word is frozen between requests so the rx side reads it whole
    if (core_ff.req_s2 != core_ff.req_s3) begin
      nxt_core.head = i_rx_head;
      nxt_core.rx_pop = 1'b1;
      nxt_core.ack_tog = ~core_ff.ack_tog;
    end
    if (!i_rstn) begin
      nxt_core = '0;
      nxt_core.cfg_s1 = CFG_RESET;
      nxt_core.cfg_s2 = CFG_RESET;
      nxt_core.full_flag = ~FLAG_ON_SHARED;
      nxt_core.empty_flag = ~FLAG_ON_SHARED;
    end
  end

  always_ff @(posedge i_clk) begin
    core_ff <= nxt_core;
  end

  // transmit outputs, plus core-domain receive reset hit and pop
  assign o_transmit_flag_oe = tx_oe;
  assign o_transmit_queue_full_flag = core_ff.full_flag;
  assign o_transmit_queue_empty_flag = core_ff.empty_flag;
  assign o_tx_write = core_ff.tx_write;
  assign o_tx_word = core_ff.tx_word;
  assign o_tx_reset_hit = tx_rst_hit;
  assign o_rx_reset_hit = core_ff.receive_queue_reset_n_s2;
  assign o_rx_pop = core_ff.rx_pop;

  // ------------------------------------------------------------
  // receive side (receive port clock domain)
  // ------------------------------------------------------------
  // reset release synchronised into the port domain
  always_ff @(posedge i_receive_port_clock) begin
    rx_rst_s1_ff <= i_rstn;
    rx_rst_s2_ff <= rx_rst_s1_ff;
  end

  port_select u_rx_select (
    .i_clk(i_receive_port_clock),
    .i_rstn(rx_rst_s2_ff),
    .i_cascade(rx_ff.cfg_s2[CFG_CASCADE]),
    .i_chip_select_n(i_chip_select_n),
    .i_reset_n(i_receive_queue_reset_n),
    .i_enable(i_receive_read_enable),
    .o_hit(),
    .o_reset_hit(rx_rst_hit),
    .o_selected(rx_sel),
    .o_take(rx_take),
    .o_flag_oe(rx_oe)
  );

  // receive state: status sync, word fetch, self-test error capture
  always_comb begin
    nxt_rx = rx_ff;
    nxt_rx.st_s1 = i_rx_status;
    nxt_rx.st_s2 = rx_ff.st_s1;
    nxt_rx.cfg_s1 = core_ff.cfg_s2;
    nxt_rx.cfg_s2 = rx_ff.cfg_s1;
    nxt_rx.ack_s1 = core_ff.ack_tog;
    nxt_rx.ack_s2 = rx_ff.ack_s1;
    nxt_rx.ack_s3 = rx_ff.ack_s2;
    // self-test forces empty and shows loop progress on full
    nxt_rx.full_flag = flag_level(rx_ff.cfg_s2[CFG_CASCADE],
      rx_ff.cfg_s2[CFG_RX_ST] ? rx_ff.st_s2.loop : rx_ff.st_s2.full);
    nxt_rx.empty_flag = flag_level(rx_ff.cfg_s2[CFG_CASCADE],
      rx_ff.cfg_s2[CFG_RX_ST] | rx_ff.st_s2.empty);
    nxt_rx.data_oe = rx_take;
    // one request at a time; a fetch costs a round trip, limiting rate
    if (rx_take && !rx_ff.cfg_s2[CFG_RX_ST] && rx_ff.req_tog == rx_ff.ack_s3) begin
      nxt_rx.req_tog = ~rx_ff.req_tog;
    end
    if (rx_ff.ack_s2 != rx_ff.ack_s3) begin
      nxt_rx.data = core_ff.head;
    end
    // with the queue enabled, error held until shown while selected; new error wins over clear
    if (rx_ff.cfg_s2[CFG_BYPASS_N]) begin
      if (rx_ff.st_s2.miscompare) begin
        nxt_rx.sticky_err = 1'b1;
      end else if (rx_take) begin
        nxt_rx.sticky_err = 1'b0;
      end
      nxt_rx.code_violation_flag = rx_ff.cfg_s2[CFG_RX_ST] & (rx_ff.sticky_err | rx_ff.st_s2.miscompare);
    end else begin
      nxt_rx.sticky_err = 1'b0;
      nxt_rx.code_violation_flag = rx_ff.cfg_s2[CFG_RX_ST] & rx_ff.st_s2.miscompare;
    end
    if (!rx_rst_s2_ff) begin
      nxt_rx = '0;
      nxt_rx.cfg_s1 = CFG_RESET;
      nxt_rx.cfg_s2 = CFG_RESET;
      nxt_rx.full_flag = ~FLAG_ON_SHARED;
      nxt_rx.empty_flag = ~FLAG_ON_SHARED;
    end
  end

  always_ff @(posedge i_receive_port_clock) begin
    rx_ff <= nxt_rx;
  end

  // receive outputs
  assign o_receive_flag_oe = rx_oe;
  assign o_receive_queue_full_flag = rx_ff.full_flag;
  assign o_receive_queue_empty_flag = rx_ff.empty_flag;
  assign o_receive_data_bus = rx_ff.data;
  assign o_code_violation_flag = rx_ff.code_violation_flag;
  assign o_receive_data_oe = rx_ff.data_oe;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_tx_capture;
    @(posedge i_clk) disable iff (!i_rstn)
      tx_take |=> o_tx_write && (o_tx_word == $past(i_transmit_data_bus));
  endproperty
  a_tx_capture: assert property (p_tx_capture) else $error("tx word not written");

  property p_tx_polarity;
    @(posedge i_clk) disable iff (!i_rstn)
      $past(i_rstn) |-> o_transmit_queue_full_flag ==
        ($past(core_ff.cfg_s2[CFG_CASCADE]) ? $past(i_tx_queue_full) : !$past(i_tx_queue_full));
  endproperty
  a_tx_polarity: assert property (p_tx_polarity) else $error("tx flag polarity");

  property p_tx_oe_cause;
    @(posedge i_clk) disable iff (!i_rstn)
      $rose(o_transmit_flag_oe) |-> $past(!i_chip_select_n);
  endproperty
  a_tx_oe_cause: assert property (p_tx_oe_cause) else $error("tx oe without cs");

  property p_rx_no_pop;
    @(posedge i_receive_port_clock) disable iff (!rx_rst_s2_ff)
      (rx_ff.cfg_s2[CFG_RX_ST] && rx_take) |=> $stable(rx_ff.req_tog);
  endproperty
  a_rx_no_pop: assert property (p_rx_no_pop) else $error("pop in self-test");

  property p_rx_driven;
    @(posedge i_receive_port_clock) disable iff (!rx_rst_s2_ff)
      rx_sel |-> o_receive_data_oe || $past(!rx_sel);
  endproperty
  a_rx_driven: assert property (p_rx_driven) else $error("rx bus not driven");

  property p_rx_error_held;
    @(posedge i_receive_port_clock) disable iff (!rx_rst_s2_ff)
      (rx_ff.cfg_s2[CFG_BYPASS_N] && rx_ff.cfg_s2[CFG_RX_ST] && rx_ff.st_s2.miscompare
        && $stable(rx_ff.cfg_s2)) |=> o_code_violation_flag;
  endproperty
  a_rx_error_held: assert property (p_rx_error_held) else $error("miscompare lost");

  property p_rx_oe_cause;
    @(posedge i_receive_port_clock) disable iff (!rx_rst_s2_ff)
      $rose(o_receive_flag_oe) |-> $past(!i_chip_select_n);
  endproperty
  a_rx_oe_cause: assert property (p_rx_oe_cause) else $error("rx oe without cs");

endmodule : shared_bus_host_selection
`default_nettype wire

// [testbench/bus_master_model.sv]
/*
  behavioural shared-bus master that polls and selects one slave port.
  assumes the bench supplies the reference clock, the receive port clock
  and the timing model level that the slave is configured for.
*/
`timescale 1ns/10ps
`default_nettype none
module bus_master_model (
  input wire logic i_clk,
  input wire logic i_rx_clk,
  input wire logic i_cascade,
  output logic o_cs_n,
  output logic o_tx_rst_n,
  output logic o_tx_en,
  output logic [shared_port_pkg::DATA_W-1:0] o_tx_data,
  output logic o_rx_rst_n,
  output logic o_rx_en
);
  import shared_port_pkg::*;

  // ------------------------------------------------------------
  // bus cycles, all launched on falling edges
  // ------------------------------------------------------------
  // idle bus: decoder output high, enables at the inactive level
  initial begin
    o_cs_n = 1'b1;
    o_tx_rst_n = 1'b1;
    o_tx_en = 1'b1;
    o_tx_data = '0;
    o_rx_rst_n = 1'b1;
    o_rx_en = 1'b1;
  end

  // address or release the slave to sample its flags; enables go idle
  task automatic poll(input bit rx, input logic cs);
    if (rx) @(negedge i_rx_clk);
    else @(negedge i_clk);
    o_cs_n = cs;
    o_tx_rst_n = 1'b1;
    o_rx_rst_n = 1'b1;
    o_tx_en = ~i_cascade;
    o_rx_en = ~i_cascade;
  endtask : poll

  // write burst: cs first, then enable; shared model wastes the fall cycle
  task automatic tx_burst(input int n, input logic [DATA_W-1:0] base);
    @(negedge i_clk);
    o_cs_n = 1'b0;
    @(negedge i_clk);
    o_tx_en = i_cascade;
    // shared model: the fall cycle carries a decoy word that must not land
    if (!i_cascade) begin
      o_tx_data = ~base;
      @(negedge i_clk);
    end
    for (int i = 0; i < n; i++) begin
      o_tx_data = base + DATA_W'(i);
      if (i < n - 1) @(negedge i_clk);
    end
    @(negedge i_clk);
    o_tx_en = ~i_cascade;
    o_tx_data = ~o_tx_data; // released bus shows no stale word
    o_cs_n = 1'b1;
  endtask : tx_burst

  // both reset lines low while addressed, then a write attempt that must be ignored
  task automatic tx_reset_try(input int n);
    @(negedge i_clk);
    o_cs_n = 1'b0;
    o_tx_rst_n = 1'b0;
    o_rx_rst_n = 1'b0;
    repeat (2) @(negedge i_clk);
    o_tx_en = i_cascade;
    repeat (n) @(negedge i_clk);
    o_tx_en = ~i_cascade;
  endtask : tx_reset_try

  // read selection on the receive port clock
  task automatic rx_select();
    @(negedge i_rx_clk);
    o_cs_n = 1'b0;
    @(negedge i_rx_clk);
    o_rx_en = i_cascade;
  endtask : rx_select

  task automatic rx_release();
    @(negedge i_rx_clk);
    o_rx_en = ~i_cascade;
    o_cs_n = 1'b1;
  endtask : rx_release
endmodule : bus_master_model
`default_nettype wire

// [testbench/tb.sv]
/*
  self-checking bench for the shared bus host port: flag drivers, write
  bursts in both timing models, bypass, reset hit and receive reads.
  assumes core status levels are modelled by the bench directly.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import shared_port_pkg::*;

  // ------------------------------------------------------------
  // clocks, design and master
  // ------------------------------------------------------------
  logic i_clk, i_rx_clk, i_rstn, cs_n, tx_rst_n, tx_en, rx_rst_n, rx_en;
  logic bypass_n, cascade, tx_st, rx_st, tx_full, tx_empty, tx_loop;
  logic [DATA_W-1:0] tx_data, rx_head;
  rx_status_t rx_status;
  logic tx_full_f, tx_empty_f, tx_oe, tx_write, tx_rst_hit, rx_pop, rx_rst_hit;
  logic rx_full_f, rx_empty_f, rx_oe, code_violation_flag, data_oe;
  logic [DATA_W-1:0] tx_word, rx_bus;
  logic [DATA_W-1:0] wq[$];
  int pops, miscompares, n_checks;

  // rx clock phase offset keeps the two domains unrelated
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    i_rx_clk = 1'b0;
    #7;
    forever #62.5 i_rx_clk = ~i_rx_clk;
  end

  shared_bus_host_selection dut (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_receive_port_clock(i_rx_clk), .i_chip_select_n(cs_n), .i_queue_bypass_n(bypass_n),
    .i_cascade_model(cascade), .i_transmit_selftest_enable(tx_st),
    .i_receive_selftest_enable(rx_st), .i_transmit_queue_reset_n(tx_rst_n),
    .i_transmit_write_enable(tx_en), .i_transmit_data_bus(tx_data),
    .i_tx_queue_full(tx_full), .i_tx_queue_empty(tx_empty), .i_tx_selftest_loop(tx_loop),
    .o_transmit_queue_full_flag(tx_full_f), .o_transmit_queue_empty_flag(tx_empty_f),
    .o_transmit_flag_oe(tx_oe), .o_tx_write(tx_write), .o_tx_word(tx_word),
    .o_tx_reset_hit(tx_rst_hit), .i_receive_queue_reset_n(rx_rst_n),
    .i_receive_read_enable(rx_en), .i_rx_status(rx_status), .i_rx_head(rx_head),
    .o_rx_pop(rx_pop), .o_rx_reset_hit(rx_rst_hit), .o_receive_queue_full_flag(rx_full_f),
    .o_receive_queue_empty_flag(rx_empty_f), .o_receive_flag_oe(rx_oe),
    .o_receive_data_bus(rx_bus), .o_code_violation_flag(code_violation_flag), .o_receive_data_oe(data_oe));

  bus_master_model mac (.i_clk(i_clk), .i_rx_clk(i_rx_clk), .i_cascade(cascade),
    .o_cs_n(cs_n), .o_tx_rst_n(tx_rst_n), .o_tx_en(tx_en), .o_tx_data(tx_data),
    .o_rx_rst_n(rx_rst_n), .o_rx_en(rx_en));

  // collect written words and queue pops at the core clock
  always @(posedge i_clk) begin
    if (tx_write === 1'b1) wq.push_back(tx_word);
    if (rx_pop === 1'b1) pops++;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tk(input int n);
    repeat (n) @(negedge i_clk);
  endtask : tk

  task automatic rk(input int n);
    repeat (n) @(negedge i_rx_clk);
  endtask : rk

  // one word per clock, nothing written outside the burst
  task automatic run_burst(input int n, input logic [DATA_W-1:0] base);
    wq.delete();
    mac.tx_burst(n, base);
    tk(4);
    chk("tx_count", DATA_W'(n), DATA_W'(wq.size()));
    for (int i = 0; i < n && i < wq.size(); i++)
      chk("tx_word", base + DATA_W'(i), wq[i]);
  endtask : run_burst

  // flag drivers follow chip select sampled on the given side
  task automatic flags(input bit rx, input logic cs, input logic exp_oe);
    mac.poll(rx, cs);
    if (rx) rk(3);
    else tk(2);
    chk(rx ? "rx_flag_oe" : "tx_flag_oe", exp_oe, rx ? rx_oe : tx_oe);
  endtask : flags

  task automatic end_sim();
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // hang guard, well beyond the expected run
  initial begin
    #400000;
    miscompares++;
    end_sim();
  end

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    {bypass_n, cascade, tx_st, rx_st, tx_full, tx_empty, tx_loop} = 7'b1000100;
    rx_status = '{full: 1'b1, empty: 1'b0, loop: 1'b0, miscompare: 1'b0};
    rx_head = 10'h2c5;
    i_rstn = 1'b0;
    miscompares = 0;
    n_checks = 0;
    pops = 0;
    // long enough for the receive domain to see reset too
    tk(20);
    i_rstn = 1'b1;
    chk("oe_after_reset", 10'h000, {tx_oe, rx_oe, data_oe});
    rk(4);
    flags(0, 1'b0, 1'b1);
    chk("tx_full", FLAG_ON_SHARED, tx_full_f);
    chk("tx_empty", 1'(~FLAG_ON_SHARED), tx_empty_f);
    flags(0, 1'b1, 1'b0);
    flags(1, 1'b0, 1'b1);
    chk("rx_full", FLAG_ON_SHARED, rx_full_f);
    flags(1, 1'b1, 1'b0);
    run_burst(5, 10'h3a0);
    cascade = 1'b1;
    rk(4);
    mac.poll(0, 1'b1);
    run_burst(4, 10'h155);
    flags(0, 1'b0, 1'b1);
    chk("tx_full_casc", FLAG_ON_CASCADE, tx_full_f);
    // release the slave before the model flips, so idle enables that look like a fall find no hit
    flags(0, 1'b1, 1'b0);
    cascade = 1'b0;
    rk(4);
    mac.poll(0, 1'b1);
    bypass_n = 1'b0;
    rk(4);
    run_burst(3, 10'h0f0);
    flags(0, 1'b0, 1'b1);
    flags(0, 1'b1, 1'b0);
    bypass_n = 1'b1;
    rk(4);
    wq.delete();
    mac.tx_reset_try(3);
    rk(2);
    chk("tx_rst_hit", 1'b1, tx_rst_hit);
    chk("rx_rst_hit", 1'b1, rx_rst_hit);
    chk("tx_oe_rst", 1'b1, tx_oe);
    chk("tx_count_rst", 10'h000, DATA_W'(wq.size()));
    flags(0, 1'b1, 1'b0);
    chk("tx_rst_hit_off", 1'b0, tx_rst_hit);
    // transmit self-test: loop status on the empty flag, same driver gating
    {tx_st, tx_loop} = 2'b11;
    tk(4);
    flags(0, 1'b0, 1'b1);
    chk("tx_loop", FLAG_ON_SHARED, tx_empty_f);
    flags(0, 1'b1, 1'b0);
    tx_st = 1'b0;
    // normal read pops the queue and drives the head word
    mac.rx_select();
    rk(8);
    chk("rx_data_oe", 1'b1, data_oe);
    chk("rx_bus", rx_head, rx_bus);
    chk("rx_pop_seen", 1'b1, (pops != 0));
    mac.rx_release();
    rk(3);
    chk("rx_data_oe_off", 1'b0, data_oe);
    // receive self-test read with a live miscompare
    rx_st = 1'b1;
    rx_status.miscompare = 1'b1;
    rk(4);
    chk("rx_oe_st_idle", 1'b0, rx_oe);
    pops = 0;
    mac.rx_select();
    rk(5);
    chk("rx_data_oe_st", 1'b1, data_oe);
    chk("code_violation_flag", 1'b1, code_violation_flag);
    chk("rx_empty_st", FLAG_ON_SHARED, rx_empty_f);
    rk(6);
    chk("rx_data_oe_held", 1'b1, data_oe);
    chk("rx_oe_st", 1'b1, rx_oe);
    mac.rx_release();
    rk(3);
    chk("rx_pop_st", 10'h000, DATA_W'(pops));
    rx_st = 1'b0;
    rx_status.miscompare = 1'b0;
    end_sim();
  end
endmodule : tb
`default_nettype wire
